// File: rtl/rswd_pkg.sv
// constants, field positions and types for the reset sources and timeout guard timer
package rswd_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CAUSE = 8'h54;
   localparam logic [7:0] ADDR_GUARD = 8'h60;
   localparam logic [7:0] ADDR_MISC = 8'h64;
   localparam logic [7:0] ADDR_RESTART = 8'h68;

   // ----------------------------------------------------------------
   // guard_control fields
   // ----------------------------------------------------------------
   localparam int GC_IRQ_FLAG = 7;
   localparam int GC_IRQ_EN = 6;
   localparam int GC_PS3 = 5;
   localparam int GC_CHG_EN = 4;
   localparam int GC_RST_EN = 3;
   localparam int GC_PS_LO = 0;

   // ----------------------------------------------------------------
   // reset_cause_flags fields and reset value
   // ----------------------------------------------------------------
   localparam int RC_SCAN = 4;
   localparam int RC_GUARD = 3;
   localparam int RC_DROP = 2;
   localparam int RC_EXT = 1;
   localparam int RC_POWER = 0;
   localparam logic [4:0] RC_RESET = 5'h01;

   // ----------------------------------------------------------------
   // misc control fields
   // ----------------------------------------------------------------
   localparam int MC_CMP_BANDGAP = 0;
   localparam int MC_CONV_EN = 1;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
   localparam int EXT_MIN_PULSE_NS = 2500;
   localparam int EXT_MIN_CYCLES = (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SUPPLY_DROP_MIN_DURATION_NS = 2000;
   localparam int SUPPLY_DROP_MIN_CYCLES =
      (SUPPLY_DROP_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STARTUP_DELAY_PERIOD_US = 4100;
   localparam int STARTUP_DELAY_DEFAULT = (STARTUP_DELAY_PERIOD_US * 1000) / CLK_PERIOD_NS;
   localparam int GUARD_BASE_OSC_CYCLES = 2048;
   localparam logic [3:0] GUARD_PS_MAX = 4'h9;
   localparam logic [2:0] DROP_LEVEL_OFF = 3'h7;

   // ----------------------------------------------------------------
   // reset sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      RS_HOLD = 3'b001,
      RS_DELAY = 3'b010,
      RS_RUN = 3'b100
   } rswd_rst_state_type;

endpackage

// File: rtl/rswd_top.sv
// reset source combiner, startup delay counter and timeout guard timer with AHB-Lite registers
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module rswd_top
   import rswd_pkg::*;
#(
   parameter int unsigned STARTUP_DELAY_CYCLES = STARTUP_DELAY_DEFAULT,
   parameter int unsigned GUARD_BASE_CYCLES = GUARD_BASE_OSC_CYCLES
)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic power_loss,
   input wire logic ext_reset_pin_b,
   input wire logic supply_drop_raw,
   input wire logic [2:0] supply_drop_level_fuse,
   input wire logic scan_reset_bit,
   input wire logic ext_reset_disable_fuse,
   input wire logic guard_always_on_fuse,
   input wire logic guard_osc_128k,
   input wire logic guard_irq_ack,
   output logic sys_reset_b,
   output logic guard_irq,
   output logic bandgap_enable
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      rswd_rst_state_type st;
      logic [31:0] delay_cnt;
      logic [7:0] ext_cnt;
      logic [7:0] drop_cnt;
      logic ext_act;
      logic drop_act;
      logic guard_pulse;
      logic osc_prev;
      logic [20:0] guard_cnt;
      logic irq_en;
      logic rst_en;
      logic [3:0] ps;
      logic [2:0] chg_cnt;
      logic irq_flag;
      logic [4:0] cause;
      logic cmp_bandgap;
      logic conv_en;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic sys_reset_b;
      logic irq;
      logic bandgap;
   } rswd_state_type;

   rswd_state_type s_q;
   rswd_state_type s_d;

   logic addr_phase;
   logic wr_go;
   logic [31:0] w;
   logic drop_en;
   logic any_src;
   logic rst_en_eff;
   logic irq_en_eff;
   logic running;
   logic tick;
   logic expire;
   logic [3:0] ps_eff;
   logic [20:0] limit;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      w = hwdata;
      addr_phase = hsel && htrans[1] && hready;
      wr_go = s_q.wr_pend;
      s_d.wr_pend = addr_phase && hwrite;
      s_d.wr_addr = haddr;

      // reset source filters
      if (ext_reset_pin_b || ext_reset_disable_fuse)
      begin
         s_d.ext_cnt = 8'h00;
         s_d.ext_act = 1'b0;
      end
      else if (s_q.ext_cnt == 8'(EXT_MIN_CYCLES - 1))
         s_d.ext_act = 1'b1;
      else
         s_d.ext_cnt = s_q.ext_cnt + 8'h01;

      drop_en = (supply_drop_level_fuse != DROP_LEVEL_OFF);
      if (!supply_drop_raw || !drop_en)
      begin
         s_d.drop_cnt = 8'h00;
         s_d.drop_act = 1'b0;
      end
      else if (s_q.drop_cnt == 8'(SUPPLY_DROP_MIN_CYCLES - 1))
         s_d.drop_act = 1'b1;
      else
         s_d.drop_cnt = s_q.drop_cnt + 8'h01;

      // reset sequencer
      any_src = power_loss || s_q.ext_act || s_q.drop_act || scan_reset_bit || s_q.guard_pulse;
      case (s_q.st)
         RS_HOLD:
         begin
            if (!any_src)
            begin
               s_d.st = RS_DELAY;
               s_d.delay_cnt = 32'(STARTUP_DELAY_CYCLES - 1);
            end
         end
         RS_DELAY:
         begin
            if (any_src)
               s_d.st = RS_HOLD;
            else if (s_q.delay_cnt == 32'h0000_0000)
               s_d.st = RS_RUN;
            else
               s_d.delay_cnt = s_q.delay_cnt - 32'h0000_0001;
         end
         RS_RUN:
         begin
            if (any_src)
               s_d.st = RS_HOLD;
         end
         default:
            s_d.st = RS_HOLD;
      endcase

      // cause flags: software writes zero to clear, sources set
      if (wr_go && s_q.wr_addr == ADDR_CAUSE)
         s_d.cause = s_q.cause & w[4:0];
      if (s_q.ext_act)
         s_d.cause[RC_EXT] = 1'b1;
      if (s_q.drop_act)
         s_d.cause[RC_DROP] = 1'b1;
      if (scan_reset_bit)
         s_d.cause[RC_SCAN] = 1'b1;
      if (s_q.guard_pulse)
         s_d.cause[RC_GUARD] = 1'b1;
      if (power_loss)
         s_d.cause = RC_RESET;

      // guard control writes and the timed change window
      if (s_q.chg_cnt != 3'h0)
         s_d.chg_cnt = s_q.chg_cnt - 3'h1;
      if (wr_go && s_q.wr_addr == ADDR_GUARD)
      begin
         s_d.irq_en = w[GC_IRQ_EN];
         if (w[GC_IRQ_FLAG])
            s_d.irq_flag = 1'b0;
         if (w[GC_CHG_EN] && w[GC_RST_EN])
         begin
            s_d.chg_cnt = CHANGE_WINDOW_CYCLES;
            s_d.rst_en = 1'b1;
         end
         else if (s_q.chg_cnt != 3'h0 && !w[GC_CHG_EN])
         begin
            s_d.rst_en = w[GC_RST_EN];
            s_d.ps = {w[GC_PS3], w[GC_PS_LO +: 3]};
            s_d.chg_cnt = 3'h0;
         end
         else
            s_d.rst_en = s_q.rst_en | w[GC_RST_EN];
      end
      if (wr_go && s_q.wr_addr == ADDR_MISC)
      begin
         s_d.cmp_bandgap = w[MC_CMP_BANDGAP];
         s_d.conv_en = w[MC_CONV_EN];
      end
      if (guard_irq_ack)
      begin
         s_d.irq_flag = 1'b0;
         s_d.irq_en = 1'b0;
      end
      if (s_q.st != RS_RUN)
      begin
         s_d.irq_en = 1'b0;
         s_d.rst_en = 1'b0;
         s_d.ps = 4'h0;
         s_d.chg_cnt = 3'h0;
         s_d.irq_flag = 1'b0;
      end

      // guard timer, counted in oscillator cycles regardless of sleep
      rst_en_eff = s_q.rst_en || s_q.cause[RC_GUARD] || guard_always_on_fuse;
      irq_en_eff = s_q.irq_en && !guard_always_on_fuse;
      running = rst_en_eff || irq_en_eff;
      ps_eff = (s_q.ps > GUARD_PS_MAX) ? GUARD_PS_MAX : s_q.ps;
      limit = 21'(GUARD_BASE_CYCLES) << ps_eff;
      s_d.osc_prev = guard_osc_128k;
      tick = guard_osc_128k && !s_q.osc_prev;
      expire = 1'b0;
      s_d.guard_pulse = 1'b0;
      if (!running || (wr_go && s_q.wr_addr == ADDR_RESTART))
         s_d.guard_cnt = 21'h000000;
      else if (tick)
      begin
         if (s_q.guard_cnt >= limit - 21'h000001)
         begin
            expire = 1'b1;
            s_d.guard_cnt = 21'h000000;
         end
         else
            s_d.guard_cnt = s_q.guard_cnt + 21'h000001;
      end
      if (expire)
      begin
         if (irq_en_eff && !(s_q.irq_flag && rst_en_eff))
            s_d.irq_flag = 1'b1;
         else if (rst_en_eff)
            s_d.guard_pulse = 1'b1;
      end

      // outputs
      s_d.sys_reset_b = (s_d.st == RS_RUN);
      s_d.irq = s_d.irq_flag && s_d.irq_en && !guard_always_on_fuse;
      s_d.bandgap = drop_en || s_d.cmp_bandgap || s_d.conv_en;

      // read data from the updated state, so a read right after a write sees it
      s_d.rdata = 32'h0000_0000;
      if (addr_phase && !hwrite)
      begin
         case (haddr)
            ADDR_CAUSE:
               s_d.rdata = {27'h0000000, s_d.cause};
            ADDR_GUARD:
               s_d.rdata = {24'h000000, s_d.irq_flag, s_d.irq_en && !guard_always_on_fuse, s_d.ps[3],
                  s_d.chg_cnt != 3'h0, s_d.rst_en || s_d.cause[RC_GUARD] || guard_always_on_fuse,
                  s_d.ps[2:0]};
            ADDR_MISC:
               s_d.rdata = {30'h00000000, s_d.conv_en, s_d.cmp_bandgap};
            default:
               s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_q <= '0;
         s_q.st <= RS_HOLD;
         s_q.cause <= RC_RESET;
      end
      else
         s_q <= s_d;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      hrdata = s_q.rdata;
      hreadyout = 1'b1;
      hresp = 1'b0;
      sys_reset_b = s_q.sys_reset_b;
      guard_irq = s_q.irq;
      bandgap_enable = s_q.bandgap;
   end

endmodule // rswd_top

// File: verif/rswd_props.sv
// assertions on reset sources, release delay and guard outputs
`timescale 1ns/1ps
module rswd_props
   import rswd_pkg::*;
#(
   parameter int unsigned STARTUP_DELAY_CYCLES = 20,
   parameter int unsigned GUARD_BASE_CYCLES = 4
)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic power_loss,
   input wire logic ext_reset_pin_b,
   input wire logic supply_drop_raw,
   input wire logic [2:0] supply_drop_level_fuse,
   input wire logic scan_reset_bit,
   input wire logic ext_reset_disable_fuse,
   input wire logic guard_always_on_fuse,
   input wire logic guard_irq_ack,
   input wire logic sys_reset_b,
   input wire logic guard_irq,
   input wire logic bandgap_enable
);
   logic [6:0] ext_n_q, drop_n_q;
   int unsigned low_n_q;
   logic pin_on, drop_on, src_on;
   assign pin_on = !ext_reset_pin_b && !ext_reset_disable_fuse;
   assign drop_on = supply_drop_raw && supply_drop_level_fuse != DROP_LEVEL_OFF;
   assign src_on = power_loss || scan_reset_bit || ext_n_q >= EXT_MIN_CYCLES || drop_n_q >= SUPPLY_DROP_MIN_CYCLES;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // saturating filters and a count of quiet cycles spent in reset
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ext_n_q <= 7'h00;
         drop_n_q <= 7'h00;
         low_n_q <= 0;
      end
      else
      begin
         ext_n_q <= pin_on ? ext_n_q + 7'(ext_n_q != 7'h7f) : 7'h00;
         drop_n_q <= drop_on ? drop_n_q + 7'(drop_n_q != 7'h7f) : 7'h00;
         low_n_q <= (sys_reset_b || src_on) ? 0 : low_n_q + 1;
      end
   end
   sequence goes_low_s;
      ##[0:4] !sys_reset_b;
   endsequence
   power_fast_a: assert property ($rose(power_loss) |-> goes_low_s)
      else $error("power loss gave no reset");
   pin_reset_a: assert property (ext_n_q == EXT_MIN_CYCLES |-> goes_low_s)
      else $error("long pin low gave no reset");
   drop_fast_a: assert property (drop_n_q == SUPPLY_DROP_MIN_CYCLES |-> goes_low_s)
      else $error("supply drop gave no reset");
   scan_hold_a: assert property (scan_reset_bit [*3] |-> !sys_reset_b)
      else $error("scan bit did not hold reset");
   delay_rel_a: assert property ($rose(sys_reset_b) |-> low_n_q >= STARTUP_DELAY_CYCLES)
      else $error("reset released early");
   bandgap_on_a: assert property ((supply_drop_level_fuse != DROP_LEVEL_OFF) [*2] |-> bandgap_enable)
      else $error("reference off with detector on");
   irq_ack_a: assert property (guard_irq_ack |-> ##[1:2] !guard_irq)
      else $error("request kept after vectoring");
   fuse_irq_a: assert property (guard_always_on_fuse [*2] |-> !guard_irq)
      else $error("request raised with fuse set");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
endmodule // rswd_props

bind rswd_top rswd_props #(.STARTUP_DELAY_CYCLES(STARTUP_DELAY_CYCLES), .GUARD_BASE_CYCLES(GUARD_BASE_CYCLES))
   i_props (.*);

// File: verif/rswd_core_model.sv
// core model: guard oscillator and interrupt vectoring after a set delay
`timescale 1ns/1ps
module rswd_core_model
#(
   parameter int OSC_HALF_NS = 200
)
(
   input wire logic clk_sys,
   input wire logic guard_irq,
   input wire logic [3:0] ack_delay,
   output logic guard_osc_128k,
   output logic guard_irq_ack
);
   int n = 0;
   initial
   begin
      guard_osc_128k = 1'b0;
      forever #(OSC_HALF_NS) guard_osc_128k = ~guard_osc_128k;
   end
   // one-cycle vector pulse once the request has stood for ack_delay plus one cycles
   always @(posedge clk_sys)
   begin
      n = guard_irq ? n + 1 : 0;
      guard_irq_ack <= (n == ack_delay + 1);
   end
endmodule // rswd_core_model

// File: verif/rswd_top_tb.sv
// self-checking bench for reset sources and timeout guard timer
`timescale 1ns/1ps
module rswd_top_tb
   import rswd_pkg::*;
;
   localparam int SD = 20;
   logic clk_sys, rst_b, hsel, hwrite, hreadyout, hresp, power_loss, ext_reset_pin_b, supply_drop_raw;
   logic scan_reset_bit, ext_reset_disable_fuse, guard_always_on_fuse, guard_osc_128k, guard_irq_ack;
   logic sys_reset_b, guard_irq, bandgap_enable, rd_pend = 1'b0;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize, supply_drop_level_fuse;
   logic [3:0] ack_delay, p;
   logic [31:0] hwdata, hrdata, r, seed = 32'hbe335cc4;
   logic [31:0] exp_q[$];
   int fail_count = 0, check_count = 0, cyc = 0, n;
   int t_m[7] = '{1, 2, 2, 4, 4, 8, 2};
   int t_len[7] = '{5, 120, 50, 100, 40, 5, 120};
   int t_c[7] = '{1, 2, 0, 4, 0, 16, 0};
   logic [3:0] t_p[3] = '{4'h0, 4'h3, 4'h9};
   rswd_top #(.STARTUP_DELAY_CYCLES(SD), .GUARD_BASE_CYCLES(4)) i_dut (.hready(hreadyout), .*);
   rswd_core_model i_core (.*);
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task finish_test();
      if (fail_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] e);
      check_count++;
      if (got !== e)
      begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, e);
      end
   endtask
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      ahb(a, 1'b0, 32'h0);
   endtask
   task gset(input logic [7:0] v);
      ahb(ADDR_RESTART, 1'b1, 32'h0);
      ahb(ADDR_GUARD, 1'b1, 32'h18);
      ahb(ADDR_GUARD, 1'b1, {24'h0, v});
   endtask
   task drive(input int m);
      power_loss <= m[0];
      ext_reset_pin_b <= !m[1];
      supply_drop_raw <= m[2];
      scan_reset_bit <= m[3];
   endtask
   task wait_ev(input int sel, output int c);
      c = 0;
      do
      begin
         @(posedge clk_sys);
         c++;
      end
      while (c < 40000 && !(sel == 0 ? guard_irq === 1'b1 : sys_reset_b === (sel == 2)));
      // a wait that runs out of cycles is a mismatch
      chk(c < 40000, 1);
   endtask
   // read data phase follows its address phase by one edge
   always @(posedge clk_sys)
   begin
      cyc++;
      if (rd_pend)
         chk(hrdata, exp_q.pop_front());
      rd_pend = hsel && htrans[1] && !hwrite;
      if (cyc == 60000)
      begin
         fail_count++;
         finish_test();
      end
   end
   initial
   begin
      {rst_b, hsel, hwrite, power_loss, supply_drop_raw, scan_reset_bit} = '0;
      {ext_reset_disable_fuse, guard_always_on_fuse, haddr, htrans, hwdata, ack_delay} = '0;
      {ext_reset_pin_b, hsize, supply_drop_level_fuse} = {1'b1, 3'h2, 3'h2};
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      wait_ev(2, n);
      chk(n >= SD, 1);
      rd(ADDR_CAUSE, 32'h1);
      ahb(ADDR_CAUSE, 1'b1, 32'h0);
      for (int k = 0; k < 7; k++)
      begin
         ext_reset_disable_fuse <= (k == 6);
         drive(t_m[k]);
         repeat (t_len[k]) @(posedge clk_sys);
         drive(0);
         chk(sys_reset_b, t_c[k] == 0);
         if (t_c[k] != 0)
            wait_ev(2, n);
         chk(t_c[k] == 0 || n >= SD, 1);
         rd(ADDR_CAUSE, t_c[k]);
         ahb(ADDR_CAUSE, 1'b1, 32'h0);
      end
      ext_reset_disable_fuse <= 1'b0;
      repeat (4)
      begin
         r = rnd();
         supply_drop_level_fuse <= r[2] ? DROP_LEVEL_OFF : {1'b0, r[4:3]};
         ahb(ADDR_MISC, 1'b1, {30'h0, r[1:0]});
         repeat (2) @(posedge clk_sys);
         chk(bandgap_enable, r[1:0] != 2'b00 || !r[2]);
         rd(ADDR_MISC, {30'h0, r[1:0]});
      end
      supply_drop_level_fuse <= DROP_LEVEL_OFF;
      foreach (t_p[i])
      begin
         r = rnd();
         ack_delay <= r[3:0];
         p = t_p[i];
         gset({2'b01, p[3], 2'b00, p[2:0]});
         wait_ev(0, n);
         // counting starts three edges before the wait, first tick lands anywhere in one oscillator period
         chk(n >= 16 * ((4 << p) - 1) - 1 && n <= 16 * ((4 << p) + 1) + 4, 1);
         chk(sys_reset_b, 1);
         repeat (24) @(posedge clk_sys);
         rd(ADDR_GUARD, {26'h0, p[3], 2'b00, p[2:0]});
      end
      gset(8'h48);
      wait_ev(0, n);
      chk(sys_reset_b, 1);
      wait_ev(1, n);
      chk(n <= 100, 1);
      wait_ev(2, n);
      chk(n >= SD, 1);
      rd(ADDR_CAUSE, 32'h08);
      rd(ADDR_GUARD, 32'h08);
      gset(8'h00);
      rd(ADDR_GUARD, 32'h08);
      ahb(ADDR_CAUSE, 1'b1, 32'h0);
      gset(8'h00);
      rd(ADDR_GUARD, 32'h0);
      ahb(ADDR_GUARD, 1'b1, 32'h18);
      repeat (6) @(posedge clk_sys);
      ahb(ADDR_GUARD, 1'b1, 32'h0);
      rd(ADDR_GUARD, 32'h08);
      gset(8'h00);
      guard_always_on_fuse <= 1'b1;
      ahb(ADDR_GUARD, 1'b1, 32'h40);
      rd(ADDR_GUARD, 32'h08);
      wait_ev(1, n);
      chk(n <= 100, 1);
      guard_always_on_fuse <= 1'b0;
      wait_ev(2, n);
      ahb(ADDR_CAUSE, 1'b1, 32'h0);
      gset(8'h00);
      rd(ADDR_GUARD, 32'h0);
      repeat (2) @(posedge clk_sys);
      finish_test();
   end
endmodule // rswd_top_tb
